// ==== src/fasm_pkg.sv ====
// Package: geometry, command codes, discoverable-parameter layout and state codes
// Assumes: shared by the array top, its command decoder and the parameter ROM
package fasm_pkg;

  // Main array geometry
  localparam int unsigned ARRAY_BYTES   = 1048576;
  localparam int unsigned BLOCK_COUNT   = 16;
  localparam int unsigned SECTOR_COUNT  = 256;
  localparam int unsigned PAGE_COUNT    = 4096;
  localparam int unsigned PAGE_BYTES    = ARRAY_BYTES / PAGE_COUNT;
  localparam int unsigned SECTOR_BYTES  = ARRAY_BYTES / SECTOR_COUNT;
  localparam int unsigned BLOCK_BYTES   = ARRAY_BYTES / BLOCK_COUNT;
  localparam int unsigned ARRAY_AW      = 20;
  localparam int unsigned SECTOR_LSB    = 12;
  localparam int unsigned BLOCK_LSB     = 16;
  localparam int unsigned PAGE_LSB      = 8;

  // Security register space: register k at k*1000h, 256 bytes each
  localparam int unsigned SEC_COUNT     = 4;
  localparam int unsigned SEC_BYTES     = 256;
  localparam int unsigned SEC_IDX_LSB   = 12;
  localparam int unsigned SEC_IDX_W     = 2;

  // Command codes
  localparam logic [7:0] CMD_READ       = 8'h03;
  localparam logic [7:0] CMD_PAGE_PROG  = 8'h02;
  localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLK_ERASE  = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'hC7;
  localparam logic [7:0] CMD_SEC_READ   = 8'h48;
  localparam logic [7:0] CMD_SEC_PROG   = 8'h42;
  localparam logic [7:0] CMD_SEC_ERASE  = 8'h44;
  localparam logic [7:0] CMD_WRITE_SR2  = 8'h31;
  localparam logic [7:0] READ_DISCOVERABLE_PARAMS_CMD = 8'h5A;

  // Lock bits LB1..LB3 sit at bits 3..5 of the second status register
  localparam int unsigned SR2_LB_LSB    = 3;
  localparam logic [3:0]  LOCK_RESET    = 4'h1;

  // Erased byte value
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;

  // Discoverable-parameter layout
  localparam logic [7:0] SFDP_HDR_END   = 8'h10;
  localparam logic [7:0] SFDP_TBL_START = 8'h30;
  localparam logic [7:0] SFDP_TBL_LAST  = 8'h6F;
  localparam int unsigned SFDP_TBL_BYTES = 64;
  localparam logic [7:0] SIG_0          = 8'h53;
  localparam logic [7:0] SIG_1          = 8'h46;
  localparam logic [7:0] SIG_2          = 8'h44;
  localparam logic [7:0] SIG_3          = 8'h50;
  localparam logic [7:0] REV_MINOR      = 8'h06;
  localparam logic [7:0] REV_MAJOR      = 8'h01;
  localparam logic [7:0] NUM_PHDR       = 8'h00;
  localparam logic [7:0] UNUSED_BYTE    = 8'hFF;
  localparam logic [7:0] TBL_LEN_DW     = 8'h10;

  // Decoded operation kinds
  typedef enum logic [3:0] {
    OP_NONE, OP_READ, OP_PROG, OP_ERASE, OP_LOCK
  } fasm_op_t;

  // Regions addressed by an operation
  typedef enum logic [1:0] {
    RG_ARRAY, RG_SEC, RG_SFDP
  } fasm_region_t;

  // Top-level sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_PROG  = 4'b0100,
    ST_ERASE = 4'b1000
  } fasm_state_t;

endpackage

// ==== src/fasm_req_if.sv ====
// Interface: carries a command to the decoder and a byte index to the parameter ROM
// Assumes: all members live in the single clk domain of the top
interface fasm_req_if;
  logic [7:0]            code;
  logic [23:0]           addr;
  logic [3:0]            locks;
  fasm_pkg::fasm_op_t     kind;
  fasm_pkg::fasm_region_t region;
  logic [19:0]           span;
  logic                  legal;
  logic [7:0]            rom_addr;
  logic [7:0]            rom_data;

  modport top (output code, addr, locks, rom_addr, input kind, region, span, legal, rom_data);
  modport dec (input code, addr, locks, output kind, region, span, legal);
  modport rom (input rom_addr, output rom_data);
endinterface

// ==== src/fasm_cmd_decode.sv ====
// Command decoder: classifies a code and address into an operation and its legality
// Assumes: purely combinational, inputs held stable by the top for one cycle
module fasm_cmd_decode (
  fasm_req_if.dec rq
);

  localparam int unsigned SEC_IDX_BIT_HI = fasm_pkg::SEC_IDX_LSB + fasm_pkg::SEC_IDX_W;

  // True when the address lies inside one of the four security registers
  function automatic logic sec_hit(input logic [23:0] a);
    sec_hit = (a[23:SEC_IDX_BIT_HI] == '0) && (a[11:8] == 4'h0);
  endfunction

  logic [1:0] idx;

  // Decode and permission check
  always_comb begin
    idx       = rq.addr[fasm_pkg::SEC_IDX_LSB +: fasm_pkg::SEC_IDX_W];
    rq.kind   = fasm_pkg::OP_NONE;
    rq.region = fasm_pkg::RG_ARRAY;
    rq.span   = 20'h00000;
    rq.legal  = 1'b0;
    unique case (rq.code)
      fasm_pkg::CMD_READ: begin
        rq.kind  = fasm_pkg::OP_READ;
        rq.legal = 1'b1;
      end
      fasm_pkg::CMD_PAGE_PROG: begin
        rq.kind  = fasm_pkg::OP_PROG;
        rq.legal = 1'b1;
      end
      fasm_pkg::CMD_SECT_ERASE: begin
        rq.kind  = fasm_pkg::OP_ERASE;
        rq.span  = 20'(fasm_pkg::SECTOR_BYTES - 1);
        rq.legal = 1'b1;
      end
      fasm_pkg::CMD_BLK_ERASE: begin
        rq.kind  = fasm_pkg::OP_ERASE;
        rq.span  = 20'(fasm_pkg::BLOCK_BYTES - 1);
        rq.legal = 1'b1;
      end
      fasm_pkg::CMD_CHIP_ERASE: begin
        rq.kind  = fasm_pkg::OP_ERASE;
        rq.span  = 20'(fasm_pkg::ARRAY_BYTES - 1);
        rq.legal = 1'b1;
      end
      fasm_pkg::CMD_SEC_READ: begin
        rq.kind   = fasm_pkg::OP_READ;
        rq.region = (idx == 2'd0) ? fasm_pkg::RG_SFDP : fasm_pkg::RG_SEC;
        rq.legal  = sec_hit(rq.addr);
      end
      fasm_pkg::CMD_SEC_PROG, fasm_pkg::CMD_SEC_ERASE: begin
        rq.kind   = (rq.code == fasm_pkg::CMD_SEC_PROG) ? fasm_pkg::OP_PROG
                                                        : fasm_pkg::OP_ERASE;
        rq.region = fasm_pkg::RG_SEC;
        rq.span   = 20'(fasm_pkg::SEC_BYTES - 1);
        // Register 0 is factory content; locked registers refuse change
        rq.legal  = sec_hit(rq.addr) && (idx != 2'd0) && !rq.locks[idx];
      end
      fasm_pkg::CMD_WRITE_SR2: begin
        rq.kind  = fasm_pkg::OP_LOCK;
        rq.legal = 1'b1;
      end
      fasm_pkg::READ_DISCOVERABLE_PARAMS_CMD: begin
        rq.kind   = fasm_pkg::OP_READ;
        rq.region = fasm_pkg::RG_SFDP;
        rq.legal  = 1'b1;
      end
      default: begin
        rq.kind  = fasm_pkg::OP_NONE;                   // No page erase code exists
      end
    endcase
  end

endmodule

// ==== src/fasm_sfdp_rom.sv ====
// Discoverable-parameter ROM: 256-byte read-only image of security register 0
// Assumes: byte index driven from the top's registered read pointer
module fasm_sfdp_rom #(
  parameter logic [8*fasm_pkg::SFDP_TBL_BYTES-1:0] BASIC_TABLE = '1
) (
  fasm_req_if.rom rq
);

  logic [7:0] tidx;

  // Header, one parameter header, basic table, reserved space
  always_comb begin
    tidx = rq.rom_addr - fasm_pkg::SFDP_TBL_START;
    unique case (rq.rom_addr)
      8'h00: rq.rom_data = fasm_pkg::SIG_0;
      8'h01: rq.rom_data = fasm_pkg::SIG_1;
      8'h02: rq.rom_data = fasm_pkg::SIG_2;
      8'h03: rq.rom_data = fasm_pkg::SIG_3;
      8'h04: rq.rom_data = fasm_pkg::REV_MINOR;
      8'h05: rq.rom_data = fasm_pkg::REV_MAJOR;
      8'h06: rq.rom_data = fasm_pkg::NUM_PHDR;
      8'h07: rq.rom_data = fasm_pkg::UNUSED_BYTE;
      8'h08: rq.rom_data = 8'h00;                       // Basic table identifier
      8'h09: rq.rom_data = fasm_pkg::REV_MINOR;
      8'h0A: rq.rom_data = fasm_pkg::REV_MAJOR;
      8'h0B: rq.rom_data = fasm_pkg::TBL_LEN_DW;
      8'h0C: rq.rom_data = fasm_pkg::SFDP_TBL_START;
      8'h0D: rq.rom_data = 8'h00;
      8'h0E: rq.rom_data = 8'h00;
      8'h0F: rq.rom_data = fasm_pkg::UNUSED_BYTE;
      default: begin
        // Header growth area and tail are reserved and read as erased
        if (rq.rom_addr >= fasm_pkg::SFDP_TBL_START && rq.rom_addr <= fasm_pkg::SFDP_TBL_LAST)
          rq.rom_data = BASIC_TABLE[8*tidx[5:0] +: 8];
        else
          rq.rom_data = fasm_pkg::ERASED_BYTE;
      end
    endcase
  end

endmodule

// ==== src/flash_array_sfdp_map.sv ====
// Top: main array, security registers and discoverable-parameter space behind a
// byte-wide command port from the serial front end.
// Assumes: the front end has already deserialised opcode, address and data bytes
// on clk; one command at a time, opened by cmd_start and closed by cmd_end.
//
// What this block does
// - Array holds 1 MB as 16 blocks, 256 sectors, 4096 pages.
// - Program stays in one page and only clears bits; erase sets them.
// - Erase only by sector, block or whole chip; no page erase.
// - Sector n covers n*4096 through n*4096+FFFh.
// - Four 256-byte security registers at k*1000h to k*1000h+0FFh.
// - A set lock bit forbids any later erase or program of that register.
// - Security registers 1 to 3 change and lock independently.
// - Security register 0 holds parameter content and ignores erase and program.
// - Code 5Ah reads the separate discoverable-parameter space.
// - Header starts at address zero; from 10h is reserved header space.
// - Basic table spans 30h to 6Fh; 70h to FFh is reserved.
// - One parameter table, the basic table, placed after the header.
// - Byte 00h reads 53h.
// - Byte 04h reads 06h and byte 05h reads 01h.
// - Byte 06h reads 00h and byte 07h reads FFh.
module flash_array_sfdp_map #(
  parameter logic [8*fasm_pkg::SFDP_TBL_BYTES-1:0] BASIC_TABLE = '1
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        cmd_start,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [23:0] cmd_addr,
  input  wire logic        data_valid,
  input  wire logic [7:0]  data_in,
  input  wire logic        cmd_end,
  output logic             busy,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             cmd_reject,
  output logic [3:0]       lock_bits
);

  localparam int unsigned AW = fasm_pkg::ARRAY_AW;

  // Reset release through two flops
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // Storage: main array and four security register slots; only 1 to 3 are ever written
  logic [7:0] mem     [fasm_pkg::ARRAY_BYTES];
  logic [7:0] sec_mem [fasm_pkg::SEC_COUNT * fasm_pkg::SEC_BYTES];

  fasm_req_if rq ();

  fasm_cmd_decode u_dec (
    .rq (rq)
  );

  fasm_sfdp_rom #(
    .BASIC_TABLE (BASIC_TABLE)
  ) u_rom (
    .rq (rq)
  );

  // Sequencer state
  fasm_pkg::fasm_state_t  state,  next_state;
  fasm_pkg::fasm_region_t region, next_region;
  logic [AW-1:0]          ptr,    next_ptr;
  logic [AW-1:0]          left,   next_left;
  logic [1:0]             sidx,   next_sidx;
  logic [3:0]             locks,  next_locks;
  logic                   next_busy;
  logic                   next_rsp_valid;
  logic [7:0]             next_rsp_data;
  logic                   next_cmd_reject;

  // Write strobes into the arrays, computed alongside the sequencer
  logic                   mem_we;
  logic                   sec_we;
  logic [7:0]             wr_byte;
  logic [9:0]             sec_wa;

  assign rq.code     = cmd_code;
  assign rq.addr     = cmd_addr;
  assign rq.locks    = locks;
  assign rq.rom_addr = ptr[7:0];
  assign sec_wa      = {sidx, ptr[7:0]};

  // Sequencer next-state logic
  always_comb begin
    next_state      = state;
    next_region     = region;
    next_ptr        = ptr;
    next_left       = left;
    next_sidx       = sidx;
    next_locks      = locks;
    next_rsp_valid  = 1'b0;
    next_rsp_data   = rsp_data;
    next_cmd_reject = 1'b0;
    mem_we          = 1'b0;
    sec_we          = 1'b0;
    wr_byte         = fasm_pkg::ERASED_BYTE;
    unique case (state)
      fasm_pkg::ST_IDLE: begin
        if (cmd_start) begin
          next_region = rq.region;
          next_sidx   = cmd_addr[fasm_pkg::SEC_IDX_LSB +: fasm_pkg::SEC_IDX_W];
          next_ptr    = cmd_addr[AW-1:0];
          if (!rq.legal) begin
            next_cmd_reject = 1'b1;
          end else begin
            unique case (rq.kind)
              fasm_pkg::OP_READ: begin
                next_state = fasm_pkg::ST_READ;
              end
              fasm_pkg::OP_PROG: begin
                next_state = fasm_pkg::ST_PROG;
              end
              fasm_pkg::OP_ERASE: begin
                // Align the start down to the erase unit so a unit is wiped whole
                next_ptr   = cmd_addr[AW-1:0] & ~rq.span;
                next_left  = rq.span;
                next_state = fasm_pkg::ST_ERASE;
              end
              default: begin
                next_state = fasm_pkg::ST_IDLE;
              end
            endcase
          end
        end
      end
      fasm_pkg::ST_READ: begin
        if (cmd_end) begin
          next_state = fasm_pkg::ST_IDLE;
        end else if (data_valid) begin
          next_rsp_valid = 1'b1;
          unique case (region)
            fasm_pkg::RG_SFDP: next_rsp_data = rq.rom_data;
            fasm_pkg::RG_SEC:  next_rsp_data = sec_mem[sec_wa];
            default:           next_rsp_data = mem[ptr];
          endcase
          // Register spaces wrap inside their 256 bytes, the array wraps at 1 MB
          if (region == fasm_pkg::RG_ARRAY)
            next_ptr = ptr + AW'(1);
          else
            next_ptr = {ptr[AW-1:8], ptr[7:0] + 8'h01};
        end
      end
      fasm_pkg::ST_PROG: begin
        if (cmd_end) begin
          next_state = fasm_pkg::ST_IDLE;
        end else if (data_valid) begin
          // Only clears bits: a 0 already stored cannot return to 1
          if (region == fasm_pkg::RG_SEC) begin
            wr_byte = sec_mem[sec_wa] & data_in;
            sec_we  = 1'b1;
          end else begin
            wr_byte = mem[ptr] & data_in;
            mem_we  = 1'b1;
          end
          // Offset wraps inside the page, the page number never moves
          next_ptr = {ptr[AW-1:fasm_pkg::PAGE_LSB], ptr[7:0] + 8'h01};
        end
      end
      fasm_pkg::ST_ERASE: begin
        // One byte per cycle; the front end waits on busy
        if (region == fasm_pkg::RG_SEC)
          sec_we = 1'b1;
        else
          mem_we = 1'b1;
        next_ptr = ptr + AW'(1);
        next_left = left - AW'(1);
        if (left == '0)
          next_state = fasm_pkg::ST_IDLE;
      end
      default: begin
        next_state = fasm_pkg::ST_IDLE;
      end
    endcase
    // Lock bits are one-time: writes can only add locks, never drop them
    if (state == fasm_pkg::ST_IDLE && cmd_start && rq.legal && rq.kind == fasm_pkg::OP_LOCK)
      next_state = fasm_pkg::ST_PROG;
    if (state == fasm_pkg::ST_PROG && cmd_code == fasm_pkg::CMD_WRITE_SR2 && data_valid) begin
      mem_we     = 1'b0;
      next_locks = locks | {data_in[fasm_pkg::SR2_LB_LSB +: 3], 1'b0};
    end
    next_busy = (next_state == fasm_pkg::ST_ERASE);
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state      <= fasm_pkg::ST_IDLE;
      region     <= fasm_pkg::RG_ARRAY;
      ptr        <= '0;
      left       <= '0;
      sidx       <= 2'h0;
      locks      <= fasm_pkg::LOCK_RESET;
      busy       <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_data   <= 8'h00;
      cmd_reject <= 1'b0;
      lock_bits  <= fasm_pkg::LOCK_RESET;
    end else begin
      state      <= next_state;
      region     <= next_region;
      ptr        <= next_ptr;
      left       <= next_left;
      sidx       <= next_sidx;
      locks      <= next_locks;
      busy       <= next_busy;
      rsp_valid  <= next_rsp_valid;
      rsp_data   <= next_rsp_data;
      cmd_reject <= next_cmd_reject;
      lock_bits  <= next_locks;
    end
  end

  // Array writes; contents carry no reset, as in a real nonvolatile cell
  always_ff @(posedge clk) begin
    if (mem_we)
      mem[ptr] <= wr_byte;
    if (sec_we && sidx != 2'd0)
      sec_mem[sec_wa] <= wr_byte;
  end

endmodule

// ==== verification/fasm_chk_sva.sv ====
// Checker: port-level properties of the array and parameter-space top
// Assumes: bound to flash_array_sfdp_map, one clk domain, no command before reset ends
module fasm_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        cmd_start,
  input wire logic [7:0]  cmd_code,
  input wire logic [23:0] cmd_addr,
  input wire logic        data_valid,
  input wire logic        cmd_end,
  input wire logic        busy,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_data,
  input wire logic        cmd_reject,
  input wire logic [3:0]  lock_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic idle, next_idle, rd_open, next_rd_open, busy_q, take;
  logic sec;
  assign take = cmd_start && idle && !busy;
  assign sec  = cmd_code inside {8'h42, 8'h44};
  // Rebuild the open-command state from the ports alone
  always_comb begin
    next_idle    = idle;
    next_rd_open = rd_open;
    if (take) begin
      next_idle    = 1'b0;
      next_rd_open = cmd_code inside {8'h03, 8'h48, 8'h5A};
    end
    if (cmd_end || cmd_reject || (busy_q && !busy)) begin
      next_idle    = 1'b1;
      next_rd_open = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle    <= 1'b1;
      rd_open <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      idle    <= next_idle;
      rd_open <= next_rd_open;
      busy_q  <= busy;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_unknown_refused: assert property (take && !(cmd_code inside {8'h03, 8'h02, 8'h20,
    8'hD8, 8'hC7, 8'h48, 8'h42, 8'h44, 8'h31, 8'h5A}) |=> cmd_reject)
    else $error("unknown opcode accepted");
  a_range_refused: assert property (take && (sec || cmd_code == 8'h48)
    && (cmd_addr[23:14] != 0 || cmd_addr[11:8] != 0) |=> cmd_reject)
    else $error("security address out of range accepted");
  a_reg0_refused: assert property (take && sec && cmd_addr[23:8] == 0 |=> cmd_reject)
    else $error("change of parameter register accepted");
  a_locked_refused: assert property (take && sec && cmd_addr[23:14] == 0
    && lock_bits[cmd_addr[13:12]] |=> cmd_reject) else $error("locked register changed");
  a_read_answer: assert property (rd_open && data_valid && !cmd_end && !cmd_reject
    |=> rsp_valid) else $error("read byte not answered");
  a_answer_cause: assert property (rsp_valid |-> $past(rd_open) && $past(data_valid))
    else $error("answer without request");
  a_data_holds: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("read data moved without answer");
  a_lock_sticky: assert property ((lock_bits & $past(lock_bits)) == $past(lock_bits))
    else $error("lock bit cleared");
  a_reg0_fixed: assert property (lock_bits[0]) else $error("parameter register unlocked");
  a_sector_busy: assert property (take && cmd_code == 8'h20 |=> busy [*8])
    else $error("sector erase not busy");
  cover property (take && cmd_code == 8'h5A);
  cover property (cmd_reject);
  cover property ($rose(busy));
  cover property ($changed(lock_bits));
endmodule

bind flash_array_sfdp_map fasm_chk u_fasm_chk (.clk, .rst_b, .cmd_start, .cmd_code,
  .cmd_addr, .data_valid, .cmd_end, .busy, .rsp_valid, .rsp_data, .cmd_reject, .lock_bits);

// ==== verification/fasm_host.sv ====
// Host model: issues commands on the byte-wide port and collects read bytes
// Assumes: one clk domain; outputs change just after rising edges
module fasm_host (
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_data,
  input  wire logic        cmd_reject,
  output logic             cmd_start,
  output logic [7:0]       cmd_code,
  output logic [23:0]      cmd_addr,
  output logic             data_valid,
  output logic [7:0]       data_in,
  output logic             cmd_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rq [$];
  logic       rej;
  initial begin
    cmd_start  = 1'b0;
    cmd_code   = 8'h00;
    cmd_addr   = 24'h000000;
    data_valid = 1'b0;
    data_in    = 8'h00;
    cmd_end    = 1'b0;
    rej        = 1'b0;
  end
  // Sample answers and refusals at the edge, before the design updates them
  always @(posedge clk) begin
    if (rsp_valid) rq.push_back(rsp_data);
    if (cmd_reject) rej = 1'b1;
  end
  // Open, send n beats (gap idle cycles after each), optionally close, wait out erase
  task automatic op(input logic [7:0] c, input logic [23:0] a, input int n,
                    input logic [15:0] d, input bit fin, input int gap);
    int i;
    rq.delete();
    rej = 1'b0;
    @(posedge clk);
    cmd_start <= 1'b1;
    cmd_code  <= c;
    cmd_addr  <= a;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      cmd_start  <= 1'b0;
      data_valid <= 1'b1;
      data_in    <= i[0] ? d[15:8] : d[7:0];
      repeat (gap) begin
        @(posedge clk);
        data_valid <= 1'b0;
        data_in    <= ~data_in;
      end
    end
    @(posedge clk);
    // Released lines are scrambled so stale values never look valid
    cmd_start  <= 1'b0;
    data_valid <= 1'b0;
    data_in    <= ~data_in;
    cmd_code   <= ~c;
    cmd_addr   <= ~a;
    cmd_end    <= fin;
    @(posedge clk);
    cmd_end <= 1'b0;
    for (i = 0; busy && i < 70000; i++) @(posedge clk);
    @(negedge clk);
  endtask
endmodule

// ==== verification/tb_top.sv ====
// Testbench: drives the array top through the host model and judges its answers
// Assumes: design under src/, checker bound from its own file
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_b, cmd_start, data_valid, cmd_end;
  logic        busy, rsp_valid, cmd_reject;
  logic [7:0]  cmd_code, data_in, rsp_data;
  logic [23:0] cmd_addr;
  logic [3:0]  lock_bits;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;

  flash_array_sfdp_map #(.BASIC_TABLE({64{8'hA5}})) u_flash_array_sfdp_map (
    .clk(clk), .rst_b(rst_b), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .data_valid(data_valid), .data_in(data_in), .cmd_end(cmd_end),
    .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .cmd_reject(cmd_reject),
    .lock_bits(lock_bits));
  fasm_host u_host (
    .clk(clk), .busy(busy), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .cmd_reject(cmd_reject), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .data_valid(data_valid), .data_in(data_in), .cmd_end(cmd_end));

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chkf(input string nm, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, s);
    end
  endtask
  // Two-byte read, low byte of e expected first
  task automatic rd2(input logic [7:0] c, input logic [23:0] a, input logic [15:0] e);
    u_host.op(c, a, 2, 16'h0000, 1'b1, 0);
    chk("read lo", e[7:0], u_host.rq[0]);
    chk("read hi", e[15:8], u_host.rq[1]);
  endtask
  task automatic stop_test();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Full header read, checked before anything else is trusted
  task automatic t_header();
    logic [7:0] hdr [8] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hFF};
    u_host.op(8'h5A, 24'h000000, 8, 16'h0000, 1'b1, 0);
    chk("count", 8'h08, 8'(u_host.rq.size()));
    for (int i = 0; i < 8; i++) chk("header", hdr[i], u_host.rq[i]);
  endtask
  // Refused opens: page-erase-like code, parameter register, out-of-range index
  task automatic t_refuse();
    logic [31:0] v [5] = '{32'h81000000, 32'h44000000, 32'h42000000, 32'h48000100,
                           32'h48004000};
    for (int i = 0; i < 5; i++) begin
      u_host.op(v[i][31:24], v[i][23:0], 0, 16'h0000, 1'b0, 0);
      chkf("refused", 1'b1, u_host.rej);
    end
    u_host.op(8'h48, 24'h0030FF, 1, 16'h0000, 1'b1, 0);
    chkf("refused", 1'b0, u_host.rej);
  endtask
  // Boundaries of the parameter map, plus register 0 after refused changes
  task automatic t_map();
    logic [31:0] v [6] = '{32'h5A002FFF, 32'h5A0030A5, 32'h5A006FA5, 32'h5A0070FF,
                           32'h5A00FFFF, 32'h48000053};
    for (int i = 0; i < 6; i++) begin
      u_host.op(v[i][31:24], {8'h00, v[i][23:8]}, 1, 16'h0000, 1'b1, 0);
      chk("map", v[i][7:0], u_host.rq[0]);
    end
    u_host.op(8'h5A, 24'h0000FF, 2, 16'h0000, 1'b1, 1);
    chk("wrap", 8'h53, u_host.rq[1]);
  endtask
  // Register 1: erase, then two programs only clear bits
  task automatic t_secreg();
    u_host.op(8'h44, 24'h001000, 0, 16'h0000, 1'b0, 0);
    chkf("refused", 1'b0, u_host.rej);
    rd2(8'h48, 24'h001000, 16'hFFFF);
    u_host.op(8'h42, 24'h001000, 2, 16'h5AA5, 1'b1, 0);
    u_host.op(8'h42, 24'h001000, 2, 16'h3C3C, 1'b1, 1);
    rd2(8'h48, 24'h001000, 16'h1824);
  endtask
  // Lock register 2 only; register 1 stays open
  task automatic t_lock();
    u_host.op(8'h31, 24'h000000, 2, 16'h1010, 1'b1, 0);
    chk("locks", 8'h05, {4'h0, lock_bits});
    u_host.op(8'h42, 24'h002000, 0, 16'h0000, 1'b0, 0);
    chkf("refused", 1'b1, u_host.rej);
    u_host.op(8'h44, 24'h002010, 0, 16'h0000, 1'b0, 0);
    chkf("refused", 1'b1, u_host.rej);
    u_host.op(8'h42, 24'h001000, 1, 16'h00F0, 1'b1, 0);
    chkf("refused", 1'b0, u_host.rej);
    rd2(8'h48, 24'h001000, 16'h1820);
  endtask
  // Sector erase from a mid-sector address, then a program that wraps in its page
  task automatic t_array();
    u_host.op(8'h20, 24'h001234, 0, 16'h0000, 1'b0, 0);
    chkf("refused", 1'b0, u_host.rej);
    rd2(8'h03, 24'h001000, 16'hFFFF);
    rd2(8'h03, 24'h001FFE, 16'hFFFF);
    u_host.op(8'h02, 24'h0012FF, 2, 16'h2211, 1'b1, 0);
    rd2(8'h03, 24'h0012FF, 16'hFF11);
    rd2(8'h03, 24'h001200, 16'hFF22);
  endtask
  // Block erase from a mid-block address; the block below keeps its data
  task automatic t_block();
    u_host.op(8'hD8, 24'h01ABCD, 0, 16'h0000, 1'b0, 0);
    chkf("refused", 1'b0, u_host.rej);
    rd2(8'h03, 24'h010000, 16'hFFFF);
    rd2(8'h03, 24'h01FFFE, 16'hFFFF);
    rd2(8'h03, 24'h0012FF, 16'hFF11);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cut a hang short well beyond the block erase, two smaller erases and the reads
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_header();
    t_refuse();
    t_map();
    t_secreg();
    t_lock();
    t_array();
    t_block();
    stop_test();
  end
endmodule
